/* design/imd_pkg.sv */
package imd_pkg;
  localparam logic [11:0] OFS_OPTIONS = 12'h404;
  localparam logic [11:0] OFS_ADDR_LOW = 12'h405;
  localparam logic [11:0] OFS_ADDR_MID = 12'h406;
  localparam logic [11:0] OFS_TEST_CTL = 12'h407;
  localparam logic [11:0] OFS_TEST_DATA = 12'h408;
  localparam logic [11:0] OFS_OBSERVE = 12'h409;
  localparam logic [11:0] OFS_SNAP_LOW = 12'h40a;
  localparam int OPT_ALT_DOWN_BIT = 6;
  localparam int OPT_GROUPING_LSB = 4;
  localparam int OPT_EXT_HEC_BIT = 3;
  localparam int CTL_SEL_LSB = 4;
  localparam int CTL_ADDR20_BIT = 7;
  localparam int OBS_WCNT_MSB_BIT = 5;
  localparam logic [7:0] OPTIONS_RST = 8'h00;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [4:0] PORT_RST = 5'h00;
  localparam logic [7:0] OPTIONS_WMASK = 8'h7f;
  localparam logic [7:0] OBSERVE_WMASK = 8'h1f;
  localparam logic [2:0] SEL_NORMAL = 3'h0;
  localparam logic [2:0] SEL_SRAM = 3'h1;
  localparam int SRAM_RD_CYCLES = 1;
  typedef enum logic [1:0] {IMD_IDLE, IMD_RD_WAIT, IMD_RD_TAKE} imd_tst_e;
endpackage : imd_pkg

/* design/imd_diag_config.sv */
// Strobed register access was left to the implementer.
`timescale 1ns/10ps
module imd_diag_config
  import imd_pkg::*;
#(
  parameter int NUM_GROUPS = 16,
  parameter int NUM_PORTS = 32,
  parameter int WCNT_W = 9
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [11:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [NUM_GROUPS-1:0] group_up_i,
  input wire logic [NUM_GROUPS-1:0] group_cav_i,
  input wire logic [NUM_GROUPS-1:0] group_all_cav_i,
  output logic [NUM_GROUPS-1:0] tx_cell_avail_out_o,
  output logic [1:0] phy_grouping_field_o,
  input wire logic [7:0] rx_hec_byte_i,
  input wire logic rx_hec_valid_i,
  input wire logic own_hec_err_i,
  output logic hec_err_o,
  input wire logic [4:0] tx_cell_bus_address_i,
  input wire logic [4:0] tx_cell_bus_address_ref_i,
  output logic tx_addr_match_o,
  input wire logic [4:0] rx_cell_bus_address_i,
  input wire logic [4:0] rx_cell_bus_address_ref_i,
  output logic rx_addr_match_o,
  output logic sram_test_o,
  output logic [20:0] sram_addr_o,
  output logic [7:0] sram_wdata_o,
  output logic sram_we_o,
  output logic sram_re_o,
  input wire logic [7:0] sram_rdata_i,
  output logic [4:0] observe_port_o,
  input wire logic [NUM_PORTS*WCNT_W-1:0] port_wcnt_i,
  input wire logic [NUM_PORTS-1:0] port_rphase_zero_i
);

  initial
  begin
    // the counter msb goes to the port-select register and its low byte to the snapshot register,
    // so anything narrower than nine bits would leave a hole in the readback
    if (NUM_PORTS < 1 || NUM_PORTS > 32 || WCNT_W < 9 || WCNT_W > 16 || NUM_GROUPS < 1)
      $error("imd_diag_config: unsupported parameters");
  end

  logic [7:0] options_r;
  logic [7:0] addr_low_r;
  logic [7:0] addr_mid_r;
  logic [7:0] test_ctl_r;
  logic [7:0] test_data_r;
  logic [4:0] port_r;
  logic [WCNT_W-1:0] snap_r;
  logic [7:0] rdata_r;
  logic [NUM_GROUPS-1:0] tx_cav_r;
  logic hec_err_r;
  logic tx_match_r;
  logic rx_match_r;
  logic sram_we_r;
  logic sram_re_r;
  logic sram_test_r;
  imd_tst_e tst_r;
  imd_tst_e tst_nxt;

  wire wr_opt = wr_i && addr_i == OFS_OPTIONS;
  wire wr_low = wr_i && addr_i == OFS_ADDR_LOW;
  wire wr_mid = wr_i && addr_i == OFS_ADDR_MID;
  wire wr_ctl = wr_i && addr_i == OFS_TEST_CTL;
  wire wr_dat = wr_i && addr_i == OFS_TEST_DATA;
  wire wr_obs = wr_i && addr_i == OFS_OBSERVE;
  wire rd_dat = rd_i && addr_i == OFS_TEST_DATA;

  wire [2:0] test_sel = test_ctl_r[CTL_SEL_LSB +: 3];
  wire test_on = test_sel == SEL_SRAM;
  wire [20:0] test_addr = {test_ctl_r[CTL_ADDR20_BIT], test_ctl_r[3:0], addr_mid_r, addr_low_r};

  // selected port counter and read-phase-zero strobe
  wire [WCNT_W-1:0] sel_wcnt = port_wcnt_i[port_r*WCNT_W +: WCNT_W];
  wire sel_rzero = port_rphase_zero_i[port_r];

  // mask selects which of bits 4..2 take part in matching
  wire [4:0] chk_mask = {options_r[2:0], 2'b11};
  wire tx_match = ((tx_cell_bus_address_i ^ tx_cell_bus_address_ref_i) & chk_mask) == 5'h00;
  wire rx_match = ((rx_cell_bus_address_i ^ rx_cell_bus_address_ref_i) & chk_mask) == 5'h00;

  // external flag in hec bit 7 or the internal checker
  wire hec_err = options_r[OPT_EXT_HEC_BIT] ? rx_hec_byte_i[7] : own_hec_err_i;

  wire [NUM_GROUPS-1:0] cav_down = options_r[OPT_ALT_DOWN_BIT] ? group_all_cav_i : '0;
  wire [NUM_GROUPS-1:0] cav_nxt = (group_up_i & group_cav_i) | (~group_up_i & cav_down);

  logic [7:0] rd_mux;
  always_comb
  begin
    case (addr_i)
      OFS_OPTIONS: rd_mux = options_r;
      OFS_ADDR_LOW: rd_mux = addr_low_r;
      OFS_ADDR_MID: rd_mux = addr_mid_r;
      OFS_TEST_CTL: rd_mux = test_ctl_r;
      OFS_TEST_DATA: rd_mux = test_data_r;
      OFS_OBSERVE: rd_mux = {2'b00, snap_r[WCNT_W-1], port_r};
      OFS_SNAP_LOW: rd_mux = snap_r[7:0];
      default: rd_mux = 8'h00;
    endcase
  end

  // a test-data read while test access is on launches an sram fetch; the byte
  // returned by the bus read is the one held before, so software reads twice
  always_comb
  begin
    tst_nxt = tst_r;
    case (tst_r)
      IMD_IDLE: if (test_on && rd_dat) tst_nxt = IMD_RD_WAIT;
      IMD_RD_WAIT: tst_nxt = IMD_RD_TAKE;
      IMD_RD_TAKE: tst_nxt = IMD_IDLE;
      default: tst_nxt = IMD_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      options_r <= OPTIONS_RST;
      addr_low_r <= ADDR_RST;
      addr_mid_r <= ADDR_RST;
      test_ctl_r <= CTL_RST;
      sram_test_r <= 1'b0;
      port_r <= PORT_RST;
    end
    else
    begin
      if (wr_opt) options_r <= wdata_i & OPTIONS_WMASK; // reserved bit held at zero
      if (wr_low) addr_low_r <= wdata_i;
      if (wr_mid) addr_mid_r <= wdata_i;
      if (wr_ctl) test_ctl_r <= wdata_i;
      // mode flag kept in its own flop so the output does not hang on a comparator
      if (wr_ctl) sram_test_r <= wdata_i[CTL_SEL_LSB +: 3] == SEL_SRAM;
      if (wr_obs) port_r <= wdata_i[4:0] & OBSERVE_WMASK[4:0];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      test_data_r <= DATA_RST;
      tst_r <= IMD_IDLE;
      sram_we_r <= 1'b0;
      sram_re_r <= 1'b0;
    end
    else
    begin
      tst_r <= tst_nxt;
      sram_we_r <= test_on && wr_dat;
      sram_re_r <= test_on && rd_dat && tst_r == IMD_IDLE;
      if (wr_dat)
        test_data_r <= wdata_i;
      else if (tst_r == IMD_RD_TAKE)
        test_data_r <= sram_rdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      snap_r <= '0;
      rdata_r <= 8'h00;
      tx_cav_r <= '0;
      hec_err_r <= 1'b0;
      tx_match_r <= 1'b0;
      rx_match_r <= 1'b0;
    end
    else
    begin
      if (sel_rzero) snap_r <= sel_wcnt;
      rdata_r <= rd_i ? rd_mux : 8'h00;
      tx_cav_r <= cav_nxt;
      hec_err_r <= rx_hec_valid_i && hec_err;
      tx_match_r <= tx_match;
      rx_match_r <= rx_match;
    end
  end

  assign rdata_o = rdata_r;
  assign tx_cell_avail_out_o = tx_cav_r;
  assign phy_grouping_field_o = options_r[OPT_GROUPING_LSB +: 2];
  assign hec_err_o = hec_err_r;
  assign tx_addr_match_o = tx_match_r;
  assign rx_addr_match_o = rx_match_r;
  assign sram_test_o = sram_test_r;
  assign sram_addr_o = test_addr;
  assign sram_wdata_o = test_data_r;
  assign sram_we_o = sram_we_r;
  assign sram_re_o = sram_re_r;
  assign observe_port_o = port_r;

  a_down_inactive: assert property (@(posedge clk_i) disable iff (rst_i)
    !options_r[OPT_ALT_DOWN_BIT] |=> ((tx_cell_avail_out_o & ~$past(group_up_i)) == '0))
    else $error("down group drives cell-available");
  a_down_alt: assert property (@(posedge clk_i) disable iff (rst_i)
    options_r[OPT_ALT_DOWN_BIT] |=>
      ((tx_cell_avail_out_o & ~$past(group_up_i)) == ($past(group_all_cav_i) & ~$past(group_up_i))))
    else $error("alternate down mode wrong");
  a_hec_select: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_hec_valid_i && options_r[OPT_EXT_HEC_BIT] |=> hec_err_o == $past(rx_hec_byte_i[7]))
    else $error("external hec flag not used");
  a_addr_mask: assert property (@(posedge clk_i) disable iff (rst_i)
    (options_r[2:0] == 3'h0 && tx_cell_bus_address_i[1:0] == tx_cell_bus_address_ref_i[1:0]) |=> tx_addr_match_o)
    else $error("masked address bits checked");
  a_test_addr: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctl |=> sram_addr_o[20:16] == {$past(wdata_i[7]), $past(wdata_i[3:0])})
    else $error("test address top bits wrong");
  a_sram_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_dat && test_on) |=> sram_we_o && sram_wdata_o == $past(wdata_i))
    else $error("test write not issued");
  a_normal_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    !test_on |=> !sram_we_o && !sram_re_o)
    else $error("sram access outside test mode");
  a_sram_fetch: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_dat && test_on && tst_r == IMD_IDLE && !wr_i) ##1 !wr_dat ##1 !wr_dat |=>
      test_data_r == $past(sram_rdata_i))
    else $error("fetched byte not held");
  a_port_sel: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_obs |=> observe_port_o == $past(wdata_i[4:0]))
    else $error("port select not stored");
  a_snapshot: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_rzero |=> snap_r == $past(sel_wcnt))
    else $error("write counter not captured");

  a_grouping_out: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_opt
    |=> phy_grouping_field_o == $past(wdata_i[OPT_GROUPING_LSB +: 2]))
    else $error("grouping field not stored");
  a_grouping_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr_opt
    |=> $stable(phy_grouping_field_o))
    else $error("grouping field changed without a write");

  a_hec_own: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_hec_valid_i && !options_r[OPT_EXT_HEC_BIT]
    |=> hec_err_o == $past(own_hec_err_i))
    else $error("own hec checker not used");
  a_hec_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !rx_hec_valid_i
    |=> !hec_err_o)
    else $error("hec error without a byte");

  a_rx_mask: assert property (@(posedge clk_i) disable iff (rst_i)
    (options_r[2:0] == 3'h0 && rx_cell_bus_address_i[1:0] == rx_cell_bus_address_ref_i[1:0])
    |=> rx_addr_match_o)
    else $error("masked rx address bits checked");

  a_addr_low: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_low
    |=> sram_addr_o[7:0] == $past(wdata_i))
    else $error("test address low byte wrong");
  a_addr_mid: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_mid
    |=> sram_addr_o[15:8] == $past(wdata_i))
    else $error("test address middle byte wrong");
  a_addr_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr_low && !wr_mid && !wr_ctl
    |=> $stable(sram_addr_o))
    else $error("test address moved without a write");
  a_test_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctl
    |=> sram_test_o == ($past(wdata_i[CTL_SEL_LSB +: 3]) == SEL_SRAM))
    else $error("test mode flag wrong");

  a_data_store: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_dat
    |=> test_data_r == $past(wdata_i))
    else $error("test data not stored");
  a_fetch_launch: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_dat && test_on && tst_r == IMD_IDLE
    |=> sram_re_o)
    else $error("test fetch not launched");
  a_fetch_single: assert property (@(posedge clk_i) disable iff (rst_i)
    sram_re_o
    |=> !sram_re_o)
    else $error("test fetch repeated");

  a_port_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr_obs
    |=> $stable(observe_port_o))
    else $error("port select changed without a write");
  a_observe_read: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_i && addr_i == OFS_OBSERVE
    |=> rdata_o == {2'b00, $past(snap_r[WCNT_W-1]), $past(port_r)})
    else $error("port select readback wrong");
  a_snap_read: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_i && addr_i == OFS_SNAP_LOW
    |=> rdata_o == $past(snap_r[7:0]))
    else $error("snapshot readback wrong");
  a_snap_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !sel_rzero
    |=> $stable(snap_r))
    else $error("snapshot changed without a strobe");

endmodule : imd_diag_config

/* sim/imd_diag_config_tb.sv */
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("Error %s exp %h got %h", n, e, g); end end
module imd_diag_config_tb;
  import imd_pkg::*;
  logic clk_i = 0;
  logic rst_i = 1;
  logic [11:0] addr_i = 0;
  logic [7:0] wdata_i = 0, rdata_o, rx_hec_byte_i = 0, sram_wdata_o, sram_rdata_i = 0, d;
  logic wr_i = 0, rd_i = 0, rx_hec_valid_i = 0, own_hec_err_i = 0, hec_err_o, tx_addr_match_o, rx_addr_match_o;
  logic sram_test_o, sram_we_o, sram_re_o;
  logic [3:0] group_up_i = 0, group_cav_i = 0, group_all_cav_i = 0, tx_cell_avail_out_o;
  logic [1:0] phy_grouping_field_o;
  logic [4:0] tx_cell_bus_address_i = 0, tx_cell_bus_address_ref_i = 0, observe_port_o;
  logic [4:0] rx_cell_bus_address_i = 0, rx_cell_bus_address_ref_i = 5'h1f;
  logic [20:0] sram_addr_o;
  logic [287:0] port_wcnt_i = 0;
  logic [31:0] port_rphase_zero_i = 0;
  int n_fail = 0;
  int n_tests = 0;
  // four groups keep the vectors short; port count stays full so select 0x1f is reachable
  imd_diag_config #(.NUM_GROUPS(4), .NUM_PORTS(32), .WCNT_W(9)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .group_up_i(group_up_i), .group_cav_i(group_cav_i), .group_all_cav_i(group_all_cav_i),
    .tx_cell_avail_out_o(tx_cell_avail_out_o), .phy_grouping_field_o(phy_grouping_field_o),
    .rx_hec_byte_i(rx_hec_byte_i), .rx_hec_valid_i(rx_hec_valid_i), .own_hec_err_i(own_hec_err_i),
    .hec_err_o(hec_err_o), .tx_cell_bus_address_i(tx_cell_bus_address_i),
    .tx_cell_bus_address_ref_i(tx_cell_bus_address_ref_i), .tx_addr_match_o(tx_addr_match_o),
    .rx_cell_bus_address_i(rx_cell_bus_address_i), .rx_cell_bus_address_ref_i(rx_cell_bus_address_ref_i),
    .rx_addr_match_o(rx_addr_match_o), .sram_test_o(sram_test_o), .sram_addr_o(sram_addr_o),
    .sram_wdata_o(sram_wdata_o), .sram_we_o(sram_we_o), .sram_re_o(sram_re_o), .sram_rdata_i(sram_rdata_i),
    .observe_port_o(observe_port_o), .port_wcnt_i(port_wcnt_i), .port_rphase_zero_i(port_rphase_zero_i));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr
  // ends just after the answer edge, so the next access may start at the very next edge
  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask : rd
  task automatic t_reset;
    for (int i = 0; i < 8; i++)
    begin
      rd(OFS_OPTIONS + 12'(i), d);
      `CHK("reset value", 8'h00, d)
    end
  endtask : t_reset
  task automatic t_options;
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_OPTIONS, 8'(i << 4)); // reserved top bit written as zero
      rd(OFS_OPTIONS, d);
      `CHK("options", 8'(i << 4), d)
      `CHK("grouping", 2'(i), phy_grouping_field_o)
    end
  endtask : t_options
  task automatic t_group;
    wr(OFS_OPTIONS, 8'h00);
    group_up_i <= 4'b0011;
    group_cav_i <= 4'b1010;
    group_all_cav_i <= 4'b0110;
    tick(2);
    `CHK("cell avail", 4'b0010, tx_cell_avail_out_o)
    wr(OFS_OPTIONS, 8'h40);
    tick(2);
    `CHK("cell avail", 4'b0110, tx_cell_avail_out_o)
  endtask : t_group
  task automatic t_hec;
    for (int x = 0; x < 4; x++)
    begin
      wr(OFS_OPTIONS, x[1] ? 8'h08 : 8'h00);
      rx_hec_byte_i <= x[0] ? 8'h80 : 8'h7f;
      own_hec_err_i <= !x[0];
      rx_hec_valid_i <= 1'b1;
      @(posedge clk_i);
      rx_hec_valid_i <= 1'b0;
      #1;
      `CHK("hec error", x[1] ? x[0] : !x[0], hec_err_o)
    end
  endtask : t_hec
  task automatic am(input logic [7:0] opt, input logic [4:0] a, input logic e);
    wr(OFS_OPTIONS, opt);
    tx_cell_bus_address_i <= a;
    rx_cell_bus_address_i <= ~a;
    tick(2);
    `CHK("tx match", e, tx_addr_match_o)
    `CHK("rx match", e, rx_addr_match_o)
  endtask : am
  task automatic t_addr;
    am(8'h00, 5'h1c, 1'b1);
    am(8'h00, 5'h01, 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      am(8'(1 << i), 5'(4 << i), 1'b0);
      am(8'(1 << i), 5'h1c & ~5'(4 << i), 1'b1);
    end
  endtask : t_addr
  task automatic t_sram;
    wr(OFS_ADDR_LOW, 8'h3c);
    wr(OFS_ADDR_MID, 8'ha5);
    wr(OFS_TEST_CTL, 8'h0a);
    `CHK("test mode", 1'b0, sram_test_o)
    wr(OFS_TEST_DATA, 8'h11);
    `CHK("sram write", 1'b0, sram_we_o)
    wr(OFS_TEST_CTL, 8'h9a);
    `CHK("test mode", 1'b1, sram_test_o)
    `CHK("sram addr", 21'h1aa53c, sram_addr_o)
    wr(OFS_TEST_DATA, 8'h5e);
    `CHK("sram write", 1'b1, sram_we_o)
    `CHK("sram wdata", 8'h5e, sram_wdata_o)
    sram_rdata_i <= 8'hc3;
    rd(OFS_TEST_DATA, d);
    `CHK("test data", 8'h5e, d)
    `CHK("sram fetch", 1'b1, sram_re_o)
    tick(3);
    rd(OFS_TEST_DATA, d);
    `CHK("fetched", 8'hc3, d)
    wr(OFS_TEST_CTL, 8'h00);
  endtask : t_sram
  task automatic t_observe;
    wr(OFS_OBSERVE, 8'h1f); // reserved top bits written as zero
    `CHK("port", 5'h1f, observe_port_o)
    port_wcnt_i[279 +: 9] <= 9'h15a;
    port_rphase_zero_i[31] <= 1'b1;
    @(posedge clk_i);
    port_rphase_zero_i[31] <= 1'b0;
    port_wcnt_i <= '0;
    tick(2);
    rd(OFS_OBSERVE, d);
    `CHK("observe", 8'h3f, d)
    rd(OFS_SNAP_LOW, d);
    `CHK("snapshot", 8'h5a, d)
  endtask : t_observe
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  initial forever #2.5 clk_i = ~clk_i;
  // the tests take well under 1000 cycles
  initial
  begin
    #20000;
    n_fail++;
    finish_test();
  end
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_options();
    t_group();
    t_hec();
    t_addr();
    t_sram();
    t_observe();
    finish_test();
  end
endmodule : imd_diag_config_tb
